//--- hdl/tmc_device.sv
/*
  Trace macrocell control device: control/status, force-stamp, rate and
  sync interval registers, sync byte counter and timestamp counter.
  Assumes the host holds req until ack; line pins are asynchronous.
*/
// Implementation choices: the register link port and the register word indices.
`timescale 1ns/10ps
`default_nettype none
module tmc_device #(
  parameter bit                      HAS_SYNC_REG  = 1'b1,
  parameter bit                      HAS_FORCE     = 1'b1,
  parameter bit                      HAS_STPV2     = 1'b1,
  parameter bit                      RATE_WRITABLE = 1'b1,
  parameter logic [tmc_pkg::DW-1:0]  RATE_INIT     = tmc_pkg::RATE_RESET
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  tmc_if.dev                         link,
  input  wire logic                  stim_write,
  input  wire logic                  stamp_sent,
  input  wire logic                  trace_byte,
  input  wire logic                  sink_busy,
  input  wire logic                  line_idle,
  input  wire logic                  ext_tick,
  output logic                       trace_en,
  output logic                       stamp_en,
  output logic                       stim_stamp,
  output logic                       force_pending,
  output logic                       sync_pulse,
  output logic                       rate_field_pulse,
  output logic [tmc_pkg::DW-1:0]     rate_field_value,
  output logic                       rate_unknown,
  output logic [tmc_pkg::DW-1:0]     stamp_count
);
  import tmc_pkg::*;

  // A writable rate register only makes sense with the v2 packet protocol
  if (RATE_WRITABLE && !HAS_STPV2) begin : g_bad_rate
    $error("writable rate register needs protocol v2");
  end

  // ------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------
  logic                  ack_q;
  wire                   take     = link.req && !ack_q;
  wire                   wr_take  = take && link.wr;
  wire                   wr_ctrl  = wr_take && (link.idx == IDX_CTRL);
  wire                   wr_force = wr_take && (link.idx == IDX_FORCE);
  wire                   wr_rate  = wr_take && (link.idx == IDX_RATE);
  wire                   wr_sync  = wr_take && (link.idx == IDX_SYNC) && HAS_SYNC_REG;

  logic                  en;
  logic                  timestamp_enable;
  logic                  sync_packet_enable;
  logic                  async_mode;
  logic [6:0]            source_id;
  logic [DW-1:0]         rate;
  logic [SYNC_W-1:0]     sync_cfg;
  logic [PERIOD_W-1:0]   remain;

  wire                   sync_packet_enable_rd = HAS_SYNC_REG ? 1'b1 : sync_packet_enable;
  wire                   busy      = en || sink_busy;
  wire [DW-1:0]          ctrl_rd   = {8'h00, busy, source_id, 11'h000, async_mode, 1'b0, sync_packet_enable_rd, timestamp_enable, en};
  wire [DW-1:0]          rate_rd   = HAS_STPV2 ? rate : 32'h00000000;
  wire [DW-1:0]          sync_rd   = HAS_SYNC_REG ? {19'h00000, sync_cfg} : 32'h00000000;
  wire [DW-1:0]          rd_mux    = (link.idx == IDX_CTRL) ? ctrl_rd :
                                     (link.idx == IDX_RATE) ? rate_rd :
                                     (link.idx == IDX_SYNC) ? sync_rd : 32'h00000000;

  assign link.ack = ack_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_q      <= 1'b0;
      link.rdata <= 32'h00000000;
    end else begin
      ack_q <= take;
      if (take && !link.wr) begin
        link.rdata <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Control/status register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en         <= 1'b0;
      timestamp_enable       <= 1'b0;
      sync_packet_enable     <= 1'b0;
      async_mode <= 1'b0;
      source_id  <= 7'h00;
    end else if (wr_ctrl) begin
      en         <= link.wdata[CTRL_EN];
      timestamp_enable       <= link.wdata[CTRL_TIMESTAMP_ENABLE];
      sync_packet_enable     <= HAS_SYNC_REG ? 1'b0 : link.wdata[CTRL_SYNC_PACKET_ENABLE];
      async_mode <= link.wdata[CTRL_ASYNC];
      source_id  <= link.wdata[CTRL_ID_HI:CTRL_ID_LO];
    end
  end

  assign trace_en = en;
  assign stamp_en = timestamp_enable;

  // ------------------------------------------------------------
  // Forced timestamp request
  // ------------------------------------------------------------
  // qualified write-one set
  wire force_set = wr_force && link.wdata[FORCE_BIT] && timestamp_enable && HAS_FORCE;

  // pend until stamped packet, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_pending <= 1'b0;
    end else if (force_set) begin
      force_pending <= 1'b1;
    end else if (stamp_sent) begin
      force_pending <= 1'b0;
    end
  end

  // Stimulus write that should carry a stamp; the sink may still drop it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stim_stamp <= 1'b0;
    end else begin
      stim_stamp <= stim_write && en && timestamp_enable && force_pending;
    end
  end

  // ------------------------------------------------------------
  // Timestamp rate register
  // ------------------------------------------------------------
  // packet only while stamping
  wire rate_ok = wr_rate && HAS_STPV2 && RATE_WRITABLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate       <= RATE_INIT;
      rate_field_pulse <= 1'b0;
      rate_field_value <= 32'h00000000;
    end else begin
      // no rate packets when stamps off
      rate_field_pulse <= rate_ok && timestamp_enable;
      if (rate_ok) begin
        rate       <= link.wdata;
        rate_field_value <= link.wdata;
      end
    end
  end

  assign rate_unknown = (rate_rd == 32'h00000000);

  // ------------------------------------------------------------
  // Sync interval and byte counter
  // ------------------------------------------------------------
  // period from mode
  function automatic logic [PERIOD_W-1:0] period_of(input logic [SYNC_W-1:0] cfg);
    logic [31:0] pow;
    pow = 32'h00000001 << cfg[SYNC_CNT_HI:SYNC_N_LO];
    if (cfg[SYNC_MODE]) begin
      period_of = pow[PERIOD_W-1:0];
    end else begin
      period_of = {16'h0000, cfg[SYNC_CNT_HI:0]};
    end
  endfunction

  wire [SYNC_W-1:0]   new_cfg   = link.wdata[SYNC_W-1:0];
  wire                counting  = HAS_SYNC_REG && (sync_cfg != 13'h0000);
  wire                sync_live = sync_packet_enable_rd && en;
  wire                period_end = trace_byte && counting && (remain <= 28'h0000001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_cfg <= SYNC_RESET;
      remain   <= 28'h0000000;
    end else if (wr_sync) begin
      sync_cfg <= new_cfg;
      remain   <= period_of(new_cfg);
    end else if (period_end) begin
      remain <= period_of(sync_cfg);
    end else if (trace_byte && counting) begin
      remain <= remain - 28'h0000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= sync_live && (wr_sync || period_end);
    end
  end

  // ------------------------------------------------------------
  // Timestamp counter
  // ------------------------------------------------------------
  logic [2:0] tick_sync;
  logic [1:0] idle_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_sync <= 3'h0;
      idle_sync <= 2'h3;
    end else begin
      tick_sync <= {tick_sync[1:0], ext_tick};
      idle_sync <= {idle_sync[0], line_idle};
    end
  end

  wire tick_rise = tick_sync[1] && !tick_sync[2];

  // external tick in async mode, else every clock; cleared while line idle in async mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stamp_count <= 32'h00000000;
    end else if (!timestamp_enable || !en || (async_mode && idle_sync[1])) begin
      stamp_count <= 32'h00000000;
    end else if (!async_mode || tick_rise) begin
      stamp_count <= stamp_count + 32'h00000001;
    end
  end
endmodule
`default_nettype wire

//--- hdl/tmc_host.sv
/*
  Control host: an AHB-Lite slave whose command registers drive single
  accesses over the register link, guarding the device's usage constraints.
  Assumes one AHB-Lite master; the slave answers with zero wait states.
*/
`timescale 1ns/10ps
`default_nettype none
module tmc_host (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  tmc_if.host                        link
);
  import tmc_pkg::*;

  typedef enum logic [4:0] {
    TMC_IDLE  = 5'b00001,
    TMC_CHECK = 5'b00010,
    TMC_JUDGE = 5'b00100,
    TMC_XFER  = 5'b01000,
    TMC_BACK  = 5'b10000
  } tmc_state_t;

  tmc_state_t     state;
  logic [31:0]    cmd;
  logic [31:0]    wdata_reg;
  logic [31:0]    rdata_reg;
  logic [31:0]    cur;
  logic           refused;
  logic           done;
  logic           a_wr;
  logic [3:0]     a_off;

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  wire         a_take  = hsel && htrans[1] && hready;
  wire         busy    = (state != TMC_IDLE);
  wire [31:0]  stat    = {29'h00000000, done, refused, busy};
  wire [31:0]  rd_mux  = (haddr[3:0] == HOFF_CMD)   ? cmd :
                         (haddr[3:0] == HOFF_WDATA) ? wdata_reg :
                         (haddr[3:0] == HOFF_RDATA) ? rdata_reg :
                         (haddr[3:0] == HOFF_STAT)  ? stat : 32'h00000000;
  wire         d_cmd   = a_wr && (a_off == HOFF_CMD);
  wire         go      = d_cmd && hwdata[CMD_GO] && !busy;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr   <= 1'b0;
      a_off  <= 4'h0;
      hrdata <= 32'h00000000;
    end else begin
      a_wr  <= a_take && hwrite;
      a_off <= haddr[3:0];
      if (a_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd       <= 32'h00000000;
      wdata_reg <= 32'h00000000;
    end else begin
      if (d_cmd && !busy) begin
        cmd <= {1'b0, hwdata[30:0]};
      end
      if (a_wr && (a_off == HOFF_WDATA) && !busy) begin
        wdata_reg <= hwdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  wire [IW-1:0] c_idx    = cmd[IW-1:0];
  wire          c_wr     = cmd[CMD_WRITE];
  wire          c_probe  = cmd[CMD_PROBE];
  wire          g_ctrl   = (hwdata[IW-1:0] == IDX_CTRL) && hwdata[CMD_WRITE];
  wire          cur_en   = cur[CTRL_EN];
  wire          cur_busy = cur[CTRL_BUSY];
  wire          id_moves = (wdata_reg[CTRL_ID_HI:CTRL_ID_LO] != cur[CTRL_ID_HI:CTRL_ID_LO]);
  wire          bad_id   = id_moves && (cur_en || cur_busy);
  wire          bad_prob = c_probe && cur_en;
  wire          refuse   = bad_id || bad_prob;

  assign link.req   = (state == TMC_CHECK) || (state == TMC_XFER) || (state == TMC_BACK);
  assign link.wr    = (state == TMC_XFER) && c_wr;
  assign link.idx   = (state == TMC_CHECK) ? IDX_CTRL : c_idx;
  assign link.wdata = wdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= TMC_IDLE;
      cur       <= 32'h00000000;
      rdata_reg <= 32'h00000000;
      refused   <= 1'b0;
      done      <= 1'b0;
    end else begin
      unique case (state)
        TMC_IDLE: begin
          if (go) begin
            refused <= 1'b0;
            done    <= 1'b0;
            // read back before a control write
            state   <= g_ctrl ? TMC_CHECK : TMC_XFER;
          end
        end
        TMC_CHECK: begin
          if (link.ack) begin
            cur   <= link.rdata;
            state <= TMC_JUDGE;
          end
        end
        TMC_JUDGE: begin
          if (refuse) begin
            refused <= 1'b1;
            done    <= 1'b1;
            state   <= TMC_IDLE;
          end else begin
            state <= TMC_XFER;
          end
        end
        TMC_XFER: begin
          // rate writes pass software's value unchanged
          if (link.ack) begin
            if (!c_wr) begin
              rdata_reg <= link.rdata;
            end
            if (c_probe && c_wr) begin
              state <= TMC_BACK;
            end else begin
              done  <= 1'b1;
              state <= TMC_IDLE;
            end
          end
        end
        TMC_BACK: begin
          if (link.ack) begin
            rdata_reg <= link.rdata;
            done      <= 1'b1;
            state     <= TMC_IDLE;
          end
        end
        default: begin
          state <= TMC_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- include/tmc_if.sv
/*
  Register link between the control host and the trace macrocell device.
  Assumes both ends share hclk; request held until acknowledge seen.
*/
`timescale 1ns/10ps
`default_nettype none
interface tmc_if;
  logic                       req;
  logic                       wr;
  logic [tmc_pkg::IW-1:0]     idx;
  logic [tmc_pkg::DW-1:0]     wdata;
  logic [tmc_pkg::DW-1:0]     rdata;
  logic                       ack;
  modport dev  (input req, input wr, input idx, input wdata, output rdata, output ack);
  modport host (output req, output wr, output idx, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

//--- include/tmc_pkg.sv
/*
  Constants shared by both ends of the trace macrocell control link:
  device register indices, field positions, reset values, host register map.
  Assumes a single 100 MHz system clock and 32-bit register data.
*/
`default_nettype none
package tmc_pkg;
  localparam int DW = 32;
  localparam int IW = 2;
  // Device register word indices (byte address is four times the index)
  localparam logic [IW-1:0] IDX_CTRL  = 2'h0;
  localparam logic [IW-1:0] IDX_FORCE = 2'h1;
  localparam logic [IW-1:0] IDX_RATE  = 2'h2;
  localparam logic [IW-1:0] IDX_SYNC  = 2'h3;
  // Control/status fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_TIMESTAMP_ENABLE   = 1;
  localparam int CTRL_SYNC_PACKET_ENABLE = 2;
  localparam int CTRL_ASYNC  = 4;
  localparam int CTRL_ID_LO  = 16;
  localparam int CTRL_ID_HI  = 22;
  localparam int CTRL_BUSY   = 23;
  localparam int FORCE_BIT   = 0;
  // Sync interval fields
  localparam int SYNC_MODE   = 12;
  localparam int SYNC_CNT_HI = 11;
  localparam int SYNC_N_LO   = 7;
  localparam int SYNC_W      = 13;
  localparam int PERIOD_W    = 28;
  localparam logic [DW-1:0]     RATE_RESET = 32'h05F5E100;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h0400;
  // Host register byte offsets on AHB-Lite
  localparam logic [3:0] HOFF_CMD   = 4'h0;
  localparam logic [3:0] HOFF_WDATA = 4'h4;
  localparam logic [3:0] HOFF_RDATA = 4'h8;
  localparam logic [3:0] HOFF_STAT  = 4'hC;
  localparam int CMD_WRITE = 8;
  localparam int CMD_PROBE = 9;
  localparam int CMD_GO    = 31;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REF  = 1;
  localparam int STAT_DONE = 2;
endpackage
`default_nettype wire

//--- sim/tmc_bench.sv
/*
  Self-checking bench: AHB-Lite master on the host, trace-side stimulus
  on the device, both ends joined by one link interface.
*/
`timescale 1ns/10ps
`default_nettype none
module tmc_bench;
  import tmc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, st, rate_field_value, stamp_count;
  logic stim_write = 0, stamp_sent = 0, trace_byte = 0, sink_busy = 0;
  logic line_idle = 1, ext_tick = 0;
  logic trace_en, stamp_en, stim_stamp, force_pending, sync_pulse, rate_field_pulse, rate_unknown;
  int fail_count = 0, checks = 0, n_sync = 0, n_rate_field = 0, n;
  tmc_if tmc_if_inst ();
  tmc_host tmc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(tmc_if_inst.host));
  tmc_device tmc_device_inst (.hclk(hclk), .hresetn(hresetn), .link(tmc_if_inst.dev),
    .stim_write(stim_write), .stamp_sent(stamp_sent), .trace_byte(trace_byte),
    .sink_busy(sink_busy), .line_idle(line_idle), .ext_tick(ext_tick), .trace_en(trace_en),
    .stamp_en(stamp_en), .stim_stamp(stim_stamp), .force_pending(force_pending),
    .sync_pulse(sync_pulse), .rate_field_pulse(rate_field_pulse), .rate_field_value(rate_field_value),
    .rate_unknown(rate_unknown), .stamp_count(stamp_count));
  tmc_link_sva tmc_link_sva_inst (.hclk(hclk), .hresetn(hresetn), .req(tmc_if_inst.req),
    .wr(tmc_if_inst.wr), .idx(tmc_if_inst.idx), .wdata(tmc_if_inst.wdata),
    .rdata(tmc_if_inst.rdata), .ack(tmc_if_inst.ack));
  initial begin
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (sync_pulse === 1'b1) n_sync++;
    if (rate_field_pulse === 1'b1) n_rate_field++;
  end
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    haddr <= {28'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // First status read may predate the command, so it is never trusted
  task automatic op(input logic [1:0] i, input logic w, input logic p, input logic [31:0] d);
    logic [31:0] t;
    ahb(1'b1, HOFF_WDATA, d, t);
    ahb(1'b1, HOFF_CMD, {1'b1, 21'h0, p, w, 6'h0, i}, t);
    for (int k = 0; k < 40; k++) begin
      ahb(1'b0, HOFF_STAT, 32'h0, st);
      if (k > 0 && st[STAT_BUSY] === 1'b0) break;
    end
    // A command still busy after the poll limit counts as a mismatch
    chk(st[STAT_BUSY], 32'h0);
    ahb(1'b0, HOFF_RDATA, 32'h0, rd);
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic bytes(input int k);
    repeat (k) begin
      trace_byte <= 1'b1;
      @(posedge hclk);
    end
    trace_byte <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    op(IDX_CTRL, 0, 0, 0);
    chk(rd, 32'h4);
    chk({30'h0, stamp_en, trace_en}, 32'h0);
    chk(hresp, 32'h0);
    op(IDX_RATE, 0, 0, 0);
    chk(rd, RATE_RESET);
    chk(rate_unknown, 0);
    op(IDX_SYNC, 0, 0, 0);
    chk(rd, {19'h0, SYNC_RESET});
    $display("test reset values done");
  endtask
  task automatic t_probe();
    op(IDX_CTRL, 1, 1, 32'h6);
    chk(st[2:0], 3'h4);
    chk(rd, 32'h6);
    op(IDX_CTRL, 0, 0, 0);
    chk(rd, 32'h6);
    op(IDX_CTRL, 1, 0, 32'h0);
    op(IDX_CTRL, 0, 0, 0);
    chk(rd, 32'h4);
    op(IDX_CTRL, 1, 0, 32'h1);
    op(IDX_CTRL, 1, 1, 32'h3);
    chk(st[2:0], 3'h6);
    op(IDX_CTRL, 0, 0, 0);
    chk(rd, 32'h00800005);
    $display("test probe done");
  endtask
  task automatic t_force();
    op(IDX_CTRL, 1, 0, 0);
    op(IDX_FORCE, 1, 0, 1);
    chk(force_pending, 0);
    op(IDX_CTRL, 1, 0, 3);
    op(IDX_FORCE, 1, 0, 0);
    chk(force_pending, 0);
    op(IDX_FORCE, 1, 0, 1);
    chk(force_pending, 1);
    op(IDX_CTRL, 1, 0, 2);
    op(IDX_CTRL, 1, 0, 3);
    chk(force_pending, 1);
    @(posedge hclk) stim_write <= 1'b1;
    @(posedge hclk) stim_write <= 1'b0;
    @(negedge hclk) chk(stim_stamp, 1);
    chk(force_pending, 1);
    @(posedge hclk) stamp_sent <= 1'b1;
    @(posedge hclk) stamp_sent <= 1'b0;
    @(negedge hclk) chk(force_pending, 0);
    @(posedge hclk) stim_write <= 1'b1;
    @(posedge hclk) stim_write <= 1'b0;
    @(negedge hclk) chk(stim_stamp, 0);
    @(posedge hclk);
    op(IDX_FORCE, 1, 0, 1);
    do_reset();
    chk(force_pending, 0);
    $display("test force stamp done");
  endtask
  task automatic t_rate();
    op(IDX_CTRL, 1, 0, 2);
    n = n_rate_field;
    op(IDX_RATE, 1, 0, 0);
    chk(32'(n_rate_field - n), 1);
    chk(rate_field_value, 0);
    chk(rate_unknown, 1);
    op(IDX_CTRL, 1, 0, 0);
    n = n_rate_field;
    op(IDX_RATE, 1, 0, 32'h0123ABCD);
    chk(32'(n_rate_field - n), 0);
    op(IDX_RATE, 0, 0, 0);
    chk(rd, 32'h0123ABCD);
    chk(rate_unknown, 0);
    $display("test rate done");
  endtask
  task automatic t_sync();
    op(IDX_CTRL, 1, 0, 1);
    n = n_sync;
    op(IDX_SYNC, 1, 0, 4);
    chk(32'(n_sync - n), 1);
    bytes(3);
    chk(32'(n_sync - n), 1);
    bytes(1);
    chk(32'(n_sync - n), 2);
    op(IDX_SYNC, 1, 0, 0);
    bytes(10);
    chk(32'(n_sync - n), 3);
    op(IDX_SYNC, 1, 0, 32'h1600);
    bytes(4095);
    chk(32'(n_sync - n), 4);
    bytes(1);
    chk(32'(n_sync - n), 5);
    op(IDX_SYNC, 0, 0, 0);
    chk(rd, 32'h1600);
    $display("test sync done");
  endtask
  task automatic t_ident();
    op(IDX_CTRL, 1, 0, 32'h00050001);
    chk(st[2:0], 3'h6);
    op(IDX_CTRL, 1, 0, 0);
    sink_busy <= 1'b1;
    op(IDX_CTRL, 1, 0, 32'h00050000);
    chk(st[2:0], 3'h6);
    sink_busy <= 1'b0;
    op(IDX_CTRL, 1, 0, 32'h00050000);
    chk(st[2:0], 3'h4);
    op(IDX_CTRL, 0, 0, 0);
    chk(rd, 32'h00050004);
    $display("test source id done");
  endtask
  task automatic t_stamp();
    logic [31:0] a;
    chk(stamp_count, 0);
    op(IDX_CTRL, 1, 0, 32'h00050013);
    chk({30'h0, stamp_en, trace_en}, 32'h3);
    repeat (5) @(posedge hclk);
    chk(stamp_count, 0);
    line_idle <= 1'b0;
    repeat (4) @(posedge hclk);
    repeat (4) begin
      ext_tick <= 1'b1;
      repeat (2) @(posedge hclk);
      ext_tick <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
    chk(stamp_count, 4);
    op(IDX_CTRL, 1, 0, 32'h00050003);
    a = stamp_count;
    repeat (10) @(posedge hclk);
    chk(stamp_count - a, 10);
    $display("test timestamp counter done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    $display("mismatch at %0t: finished %h expected %h", $time, 1'b0, 1'b1);
    fail_count++;
    summarize();
  end
  initial begin
    do_reset();
    t_reset();
    t_probe();
    t_force();
    t_rate();
    t_sync();
    t_ident();
    t_stamp();
    summarize();
  end
endmodule
`default_nettype wire

//--- sim/tmc_link_sva.sv
/*
  Concurrent checks on the register link between host and device.
  Assumes one shared hclk and an asynchronous active-low hresetn.
*/
`timescale 1ns/10ps
`default_nettype none
module tmc_link_sva (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   req,
  input wire logic                   wr,
  input wire logic [tmc_pkg::IW-1:0] idx,
  input wire logic [tmc_pkg::DW-1:0] wdata,
  input wire logic [tmc_pkg::DW-1:0] rdata,
  input wire logic                   ack
);
  import tmc_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_ctrl = ack && !wr && idx == IDX_CTRL;
  wire wr_ctrl = wr && idx == IDX_CTRL;
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  a_ack_next: assert property (s_take |=> s_answer)
    else $error("ack not one cycle after take");
  a_req_steady: assert property (s_take |=> req && $stable(wr) && $stable(idx) && $stable(wdata))
    else $error("request changed before ack");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a pending request");
  a_sync_packet_enable_one: assert property (rd_ctrl |-> rdata[CTRL_SYNC_PACKET_ENABLE])
    else $error("sync enable read as zero");
  a_busy_when_on: assert property (rd_ctrl && rdata[CTRL_EN] |-> rdata[CTRL_BUSY])
    else $error("busy clear while enabled");
  a_sync_layout: assert property (ack && !wr && idx == IDX_SYNC |-> rdata[31:13] == 19'h0)
    else $error("sync register spare bits set");
  a_check_first: assert property ($rose(req) && wr_ctrl |-> $past(ack, 2) && !$past(wr, 2))
    else $error("control write without read-back");
  a_id_guard: assert property ($rose(req) && wr_ctrl |->
      !$past(rdata[CTRL_BUSY], 2) || wdata[22:16] == $past(rdata[22:16], 2))
    else $error("source id changed while busy");
endmodule
`default_nettype wire
